// file: bench/irc_far_end.sv
// Purpose: Host and transceiver. Assumes: 768 cycle bits. Notes: none.
`timescale 1ns/1ns
module irc_far_end (
  input  wire logic clk_in,
  output var  logic uart_tx_in = 1'b1,
  output var  logic ir_pulse_in = 1'b0);
  task automatic send(input bit ir, input logic [7:0] d);
    logic [9:0] f = {1'b1, d, 1'b0};
    for (int i = 0; i < 7680; i++) begin
      @(posedge clk_in) #1;
      if (ir) ir_pulse_in = !f[i / 768] && i % 768 < 144;
      else uart_tx_in = f[i / 768];
    end
  endtask
endmodule

// file: bench/irc_power_codec_monitor.sv
// Purpose: Port checks. Assumes: one clock. Notes: bound by name.
`timescale 1ns/1ns
module irc_monitor (
  input wire logic clk_in, resetn_in, enable_in, uart_tx_in,
  input wire logic uart_rx_out, ir_pulse_out, ready_out);
  logic [10:0] en_q;
  always_ff @(posedge clk_in)
    en_q <= resetn_in && enable_in ? en_q + 11'h1 : 11'h0;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  sequence s_pulse; ##143 ir_pulse_out ##1 !ir_pulse_out; endsequence
  a_off_idle: assert property
    (!ready_out |-> !ir_pulse_out && uart_rx_out) else $error("idle");
  a_held_low: assert property
    (!enable_in [*4] |=> !ready_out) else $error("held");
  a_goes_off: assert property
    ($fell(enable_in) |-> ##[1:5] !ready_out) else $error("stop");
  a_wake_min: assert property
    ($rose(ready_out) |-> en_q >= 11'h3e8) else $error("early");
  a_wake_max: assert property
    (en_q == 11'h3f2 |-> ready_out) else $error("late");
  a_pulse_len: assert property
    ($rose(ir_pulse_out) |-> s_pulse) else $error("width");
  a_bit_grid: assert property
    ($rose(ir_pulse_out) && $past(ir_pulse_out, 768) |->
     !$past(ir_pulse_out, 769))
    else $error("grid");
  a_tx_cause: assert property
    ($rose(ir_pulse_out) |-> !$past(uart_tx_in, 4)) else $error("cause");
endmodule
bind irc_power_codec irc_monitor mon (.*);

// file: bench/tb_irc_power_codec.sv
// Purpose: Codec bench. Assumes: enable high at reset. Notes: none.
`timescale 1ns/1ns
module tb_irc_power_codec;
  logic clk_in = 0, resetn_in = 0, enable_in = 1, ir_pulse_out;
  logic uart_tx_in, ir_pulse_in, uart_rx_out, ready_out;
  logic [7:0] q[$];
  int miscompares = 0, tests_run = 0, n;
  always #5 clk_in = !clk_in;
  irc_far_end far (.*);
  irc_power_codec dut (.*);
  task check(input logic [15:0] g, e);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %0t %h %h", $time, g, e);
    end
  endtask
  task summarize;
    if (miscompares == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Any frame with no note queued is a mismatch, so idle must stay idle.
  initial forever begin
    logic [7:0] v;
    bit ir;
    @(negedge clk_in);
    if (ir_pulse_out === 1 || uart_rx_out === 0) begin
      ir = ir_pulse_out;
      repeat (ir ? 0 : 384) @(negedge clk_in);
      for (int k = 0; k < 8; k++) begin
        repeat (768) @(negedge clk_in);
        v[k] = ir ? !ir_pulse_out : uart_rx_out;
      end
      check(v, q.size() ? q.pop_front() : 'x);
      repeat (1536) @(negedge clk_in);
    end
  end
  initial begin
    void'($urandom(59));
    repeat (12) @(posedge clk_in);
    #1 resetn_in = 1;
    repeat (2) begin
      for (n = 0; ready_out !== 1 && n < 1100; n++) @(negedge clk_in);
      check(16'(n > 999 && n < 1011), 1);
      for (int i = 0; i < 2; i++) begin
        q.push_back(8'($urandom));
        far.send(i[0], q[$]);
        repeat (3000) @(posedge clk_in);
      end
      #1 enable_in = 0;
      repeat (8) @(posedge clk_in);
      far.send(0, 8'h00);
      enable_in = 1;
    end
    summarize;
  end
endmodule

// file: rtl/irc_pkg.sv
// Purpose: Shared constants for the infrared codec enable and power control.
// Assumes: One 100 MHz oscillator clock drives the whole block.
// Notes:   Cycle counts are derived from times where a time is given.
package irc_pkg;
  localparam int          CLK_PERIOD_NS   = 10;
  // Wake-up delay in oscillator periods.
  localparam int          WAKE_TOSC       = 1000;
  localparam int          WAKE_CYCLES     = WAKE_TOSC;
  localparam int          WAKE_W          = 10;
  // Bit time in bit-subclock periods and the encoded pulse window.
  localparam logic [3:0]  SUBS_LAST       = 4'hf;
  localparam logic [3:0]  PULSE_START     = 4'h7;
  localparam logic [3:0]  PULSE_END       = 4'ha;
  localparam logic [3:0]  RX_LOW_SUBS     = 4'h3;
  // Subclock at which the transmit level of the current bit is taken.
  localparam logic [3:0]  TX_SAMPLE_SUB   = 4'h3;
  // Oscillator cycles per bit subclock, less one; a fixed constant.
  localparam logic [7:0]  SUBCLK_DIV_LAST = 8'h2f;
  localparam logic [3:0]  FRAME_BITS      = 4'ha;
  localparam logic [WAKE_W-1:0] WAKE_LAST =
    WAKE_W'(WAKE_CYCLES - 1);

  typedef enum logic [1:0] {
    IRC_OFF  = 2'b00,
    IRC_WAKE = 2'b01,
    IRC_RUN  = 2'b10
  } irc_pwr_t;
endpackage

// file: rtl/irc_power_codec.sv
// Purpose: Enable control, wake-up delay and bit timing of an infrared codec.
// Assumes: Enable, transmit and pulse inputs are asynchronous and pass two flip-flops first.
// Notes:   One direction is active at a time, as the link is half duplex.
`timescale 1ns/1ns
`default_nettype none
module irc_power_codec
  import irc_pkg::*;
(
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic resetn_in,
  // Controller side
  input  wire logic enable_in,
  input  wire logic uart_tx_in,
  output var  logic uart_rx_out,
  // Transceiver side
  input  wire logic ir_pulse_in,
  output var  logic ir_pulse_out,
  // Status
  output var  logic ready_out
);

  // Synchroniser stages for enable, transmit line and pulse input.
  logic [2:0]        meta_q;
  logic [2:0]        meta_d;
  logic [2:0]        sync_q;
  logic [2:0]        sync_d;
  // Power state and wake-up counter.
  irc_pwr_t          pwr_q;
  irc_pwr_t          pwr_d;
  logic [WAKE_W-1:0] wake_q;
  logic [WAKE_W-1:0] wake_d;
  // Bit timing: oscillator divider, subclock and bit counters.
  logic [7:0]        div_q;
  logic [7:0]        div_d;
  logic [3:0]        sub_q;
  logic [3:0]        sub_d;
  logic [3:0]        bit_q;
  logic [3:0]        bit_d;
  // Direction of the frame in flight.
  logic              tx_act_q;
  logic              tx_act_d;
  logic              rx_act_q;
  logic              rx_act_d;
  // Level of the current bit in each direction.
  logic              txval_q;
  logic              txval_d;
  logic              rxlow_q;
  logic              rxlow_d;
  // Registered outputs.
  logic              irout_q;
  logic              irout_d;
  logic              rxout_q;
  logic              rxout_d;
  // Synchronised inputs and timing strobes.
  logic              en_s;
  logic              tx_s;
  logic              ir_s;
  logic              run;
  logic              tick;
  logic              bit_end;

  // True while a subclock count lies in the half-open window lo to hi.
  function automatic logic in_window(input logic [3:0] s,
                                     input logic [3:0] lo,
                                     input logic [3:0] hi);
    return (s >= lo) && (s < hi);
  endfunction

  assign en_s = sync_q[0];
  assign tx_s = sync_q[1];
  assign ir_s = sync_q[2];
  assign run  = (pwr_q == IRC_RUN);
  assign tick = (div_q == SUBCLK_DIV_LAST);
  assign bit_end = tick && (sub_q == SUBS_LAST);

  // Two-stage synchronisers; the first stage feeds only the second.
  always_comb begin
    meta_d = {ir_pulse_in, uart_tx_in, enable_in};
    sync_d = meta_q;
  end

  // Power state machine.
  always_comb begin
    pwr_d  = pwr_q;
    wake_d = wake_q;
    case (pwr_q)
      IRC_OFF: begin
        wake_d = '0;
        if (en_s) begin
          pwr_d = IRC_WAKE;
        end
      end
      IRC_WAKE: begin
        if (!en_s) begin
          pwr_d = IRC_OFF;
        end else if (wake_q == WAKE_LAST) begin
          pwr_d = IRC_RUN;
        end else begin
          wake_d = wake_q + 1'b1;
        end
      end
      IRC_RUN: begin
        if (!en_s) begin
          pwr_d = IRC_OFF;
        end
      end
      default: begin
        pwr_d = IRC_OFF;
      end
    endcase
  end

  // Codec timing. The subclock restarts on the first detected start edge,
  // so only that edge carries sampling jitter; later bits are counted.
  always_comb begin
    div_d    = div_q;
    sub_d    = sub_q;
    bit_d    = bit_q;
    tx_act_d = tx_act_q;
    rx_act_d = rx_act_q;
    txval_d  = txval_q;
    rxlow_d  = rxlow_q;
    irout_d  = 1'b0;
    rxout_d  = 1'b1;
    if (!run) begin
      // Everything idles and inputs are ignored.
      div_d    = '0;
      sub_d    = '0;
      bit_d    = '0;
      tx_act_d = 1'b0;
      rx_act_d = 1'b0;
    end else if (!tx_act_q && !rx_act_q) begin
      div_d = '0;
      sub_d = '0;
      bit_d = '0;
      if (!tx_s) begin
        tx_act_d = 1'b1;
        txval_d  = 1'b0;
      end else if (ir_s) begin
        rx_act_d = 1'b1;
        rxlow_d  = 1'b1;
      end
    end else begin
      div_d = tick ? 8'h00 : div_q + 8'h01;
      if (tick) begin
        sub_d = sub_q + 4'h1;
      end
      if (tx_act_q) begin
        // Pulse high for three subclocks of a zero bit.
        irout_d = !txval_q && in_window(sub_q, PULSE_START, PULSE_END);
        // The level is taken early in the bit, well before the pulse
        // window, so each bit encodes its own input level.
        if (tick && (sub_q == TX_SAMPLE_SUB)) begin
          txval_d = tx_s;
        end
      end else begin
        rxout_d = !rxlow_q;
        // A pulse anywhere in the first subclocks marks the bit zero; the
        // level is cleared at each bit end, so later bits share one grid.
        if (in_window(sub_q, 4'h0, RX_LOW_SUBS) && ir_s) begin
          rxlow_d = 1'b1;
        end
        if (bit_end) begin
          rxlow_d = 1'b0;
        end
      end
      if (bit_end) begin
        bit_d = bit_q + 4'h1;
        if (bit_q == FRAME_BITS - 4'h1) begin
          tx_act_d = 1'b0;
          rx_act_d = 1'b0;
          bit_d    = '0;
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meta_q   <= 3'h6;
      sync_q   <= 3'h6;
      pwr_q    <= IRC_OFF;
      wake_q   <= '0;
      div_q    <= 8'h00;
      sub_q    <= 4'h0;
      bit_q    <= 4'h0;
      tx_act_q <= 1'b0;
      rx_act_q <= 1'b0;
      txval_q  <= 1'b1;
      rxlow_q  <= 1'b0;
      irout_q  <= 1'b0;
      rxout_q  <= 1'b1;
    end else begin
      meta_q   <= meta_d;
      sync_q   <= sync_d;
      pwr_q    <= pwr_d;
      wake_q   <= wake_d;
      div_q    <= div_d;
      sub_q    <= sub_d;
      bit_q    <= bit_d;
      tx_act_q <= tx_act_d;
      rx_act_q <= rx_act_d;
      txval_q  <= txval_d;
      rxlow_q  <= rxlow_d;
      irout_q  <= irout_d;
      rxout_q  <= rxout_d;
    end
  end

  assign ir_pulse_out = irout_q;
  assign uart_rx_out  = rxout_q;
  assign ready_out    = run;

endmodule
`default_nettype wire
